// File: rtl/sdram_command_decoder.sv
/*
  Command front end of a four-bank 16-bit synchronous DRAM: samples the
  command pins, tracks bank, burst and power state, gates the data lines.
  Assumes the controller meets setup and hold at each rising clk edge.
*/
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module sdram_command_decoder
  import sdram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command pins
  input wire logic selectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeSelectN,
  input wire logic clock_gate_now,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic [ADDR_W-1:0] address_lines,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  // Data lines, split into three signals
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [DATA_W-1:0] data_lines_oe,
  // Core array side
  input wire logic [DATA_W-1:0] readData,
  output logic [DATA_W-1:0] writeData,
  output logic [1:0] writeLaneEn,
  output logic [COL_W-1:0] column,
  output logic [BANK_W-1:0] accessBank,
  output logic [ADDR_W-1:0] rowAddr,
  output logic rowOpenPulse,
  output logic refreshPulse,
  // Status
  output logic [NUM_BANKS-1:0] bankActive,
  output logic [ADDR_W-1:0] modeWord,
  output logic burstBusy,
  output logic autoPrePending,
  output pwr_e powerState
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + 1 + BANK_W + ADDR_W + 2 + DATA_W;
  logic [PIN_W-1:0] pinMetaQ, pinQ, pinD;

  always_comb begin
    pinD = {selectN, rowStrobeN, colStrobeN, writeSelectN, clock_gate_now,
      bank_select, address_lines, high_byte_mask, low_byte_mask,
      data_lines_in};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinMetaQ <= {4'hF, {(PIN_W-4){1'b0}}};
      pinQ <= {4'hF, {(PIN_W-4){1'b0}}};
    end else begin
      pinMetaQ <= pinD;
      pinQ <= pinMetaQ;
    end
  end

  logic sSel, sRas, sCas, sWe, gateNow;
  logic [BANK_W-1:0] sBank;
  logic [ADDR_W-1:0] sAddr;
  logic [1:0] sMask;
  logic [DATA_W-1:0] sData;

  always_comb begin
    {sSel, sRas, sCas, sWe, gateNow, sBank, sAddr, sMask, sData} = pinQ;
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cmd_if cmdBus();

  cmd_decode u_cmd_decode (
    .selectN(sSel),
    .rowStrobeN(sRas),
    .colStrobeN(sCas),
    .writeSelectN(sWe),
    .clockGateNow(gateNow),
    .bankSelect(sBank),
    .addressLines(sAddr),
    .cmdBus(cmdBus.decoder)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic gatePrevQ, gatePrevD;
  logic [NUM_BANKS-1:0] bankQ, bankD;
  logic [ADDR_W-1:0] modeQ, modeD;
  logic [BURST_CNT_W-1:0] burstQ, burstD;
  logic wrQ, wrD, apQ, apD;
  logic [BANK_W-1:0] apBankQ, apBankD, accBankQ, accBankD;
  logic [COL_W-1:0] colQ, colD;
  logic [ADDR_W-1:0] rowQ, rowD;
  logic openQ, openD, refQ, refD;
  pwr_e pwrQ, pwrD;
  logic cmdOk, allIdle, running;
  logic [BURST_CNT_W-1:0] burstLen;

  assign cmdBus.bankOpen = bankQ[cmdBus.bank];

  always_comb begin
    case (modeQ[BL_MSB:BL_LSB])
      BL_1: burstLen = 9'h001;
      BL_2: burstLen = 9'h002;
      BL_4: burstLen = 9'h004;
      BL_8: burstLen = 9'h008;
      default: burstLen = 9'h1FF;
    endcase
  end

  always_comb begin
    running = (pwrQ == PWR_RUN);
    allIdle = (bankQ == BANKS_IDLE);
    cmdOk = running && gatePrevQ;
    gatePrevD = gateNow;
    bankD = bankQ;
    modeD = modeQ;
    burstD = burstQ;
    wrD = wrQ;
    apD = apQ;
    apBankD = apBankQ;
    accBankD = accBankQ;
    colD = colQ;
    rowD = rowQ;
    openD = 1'b0;
    refD = 1'b0;
    pwrD = pwrQ;
    // Burst advances only while the internal clock runs
    if (running && gatePrevQ && burstQ != BURST_CNT_RST) begin
      if (modeQ[BL_MSB:BL_LSB] != BL_PAGE) begin
        burstD = burstQ - 9'h001;
      end
      colD = colQ + 9'h001;
      if (burstQ == 9'h001 && apQ) begin
        bankD[apBankQ] = 1'b0;
        apD = 1'b0;
      end
    end
    if (cmdOk) begin
      case (cmdBus.cmd)
        CMD_OPEN_ROW: begin
          bankD[cmdBus.bank] = 1'b1;
          rowD = cmdBus.addr;
          accBankD = cmdBus.bank;
          openD = 1'b1;
        end
        CMD_CLOSE_BANK: begin
          bankD[cmdBus.bank] = 1'b0;
          if (accBankQ == cmdBus.bank) begin
            burstD = BURST_CNT_RST;
          end
        end
        CMD_CLOSE_ALL: begin
          bankD = BANKS_IDLE;
          burstD = BURST_CNT_RST;
        end
        CMD_WRITE, CMD_READ: begin
          if (cmdBus.bankOpen) begin
            wrD = (cmdBus.cmd == CMD_WRITE);
            colD = cmdBus.addr[COL_W-1:0];
            accBankD = cmdBus.bank;
            burstD = burstLen;
            // Full page ignores auto-precharge
            apD = cmdBus.autoPre && modeQ[BL_MSB:BL_LSB] != BL_PAGE;
            apBankD = cmdBus.bank;
          end
        end
        CMD_MODE_SET: begin
          if (allIdle && burstQ == BURST_CNT_RST) begin
            modeD = cmdBus.addr;
          end
        end
        CMD_REFRESH: begin
          refD = allIdle;
        end
        CMD_SLEEP_ENTRY: begin
          if (allIdle) begin
            pwrD = PWR_SLEEP;
          end
        end
        CMD_BURST_STOP: begin
          burstD = BURST_CNT_RST;
          apD = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Clock-gate driven entries and exits
    case (pwrQ)
      PWR_RUN: begin
        if (gatePrevQ && !gateNow && pwrD == PWR_RUN) begin
          if (burstQ != BURST_CNT_RST) begin
            pwrD = PWR_SUSPEND;
          end else if (cmdBus.nop) begin
            pwrD = PWR_POWER_DOWN;
          end else if (!allIdle) begin
            pwrD = PWR_SUSPEND;
          end
        end
      end
      PWR_SUSPEND: begin
        if (!gatePrevQ && gateNow) begin
          pwrD = PWR_RUN;
        end
      end
      PWR_POWER_DOWN, PWR_SLEEP: begin
        if (!gatePrevQ && gateNow && cmdBus.nop) begin
          pwrD = PWR_RUN;
        end
      end
      default: pwrD = PWR_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gatePrevQ <= 1'b0;
      bankQ <= BANKS_IDLE;
      modeQ <= MODE_RST;
      burstQ <= BURST_CNT_RST;
      wrQ <= 1'b0;
      apQ <= 1'b0;
      apBankQ <= 2'h0;
      accBankQ <= 2'h0;
      colQ <= 9'h000;
      rowQ <= 12'h000;
      openQ <= 1'b0;
      refQ <= 1'b0;
      pwrQ <= PWR_RUN;
    end else begin
      gatePrevQ <= gatePrevD;
      bankQ <= bankD;
      modeQ <= modeD;
      burstQ <= burstD;
      wrQ <= wrD;
      apQ <= apD;
      apBankQ <= apBankD;
      accBankQ <= accBankD;
      colQ <= colD;
      rowQ <= rowD;
      openQ <= openD;
      refQ <= refD;
      pwrQ <= pwrD;
    end
  end

  // ----------------------------------------------------------------
  // Data lines
  // ----------------------------------------------------------------
  assign cmdBus.inBurst = (burstQ != BURST_CNT_RST) && running;
  assign cmdBus.isWrite = wrQ;
  assign cmdBus.byteMask = sMask;

  data_gate u_data_gate (
    .clk(clk),
    .sys_rst(sys_rst),
    .ctl(cmdBus.data),
    .dataIn(sData),
    .readData(readData),
    .dataOut(data_lines_out),
    .dataOe(data_lines_oe),
    .writeData(writeData),
    .writeLaneEn(writeLaneEn)
  );

  assign bankActive = bankQ;
  assign modeWord = modeQ;
  assign burstBusy = burstQ != BURST_CNT_RST;
  assign autoPrePending = apQ;
  assign powerState = pwrQ;
  assign column = colQ;
  assign accessBank = accBankQ;
  assign rowAddr = rowQ;
  assign rowOpenPulse = openQ;
  assign refreshPulse = refQ;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  open_row_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmdOk && cmdBus.cmd == CMD_OPEN_ROW |=> bankActive[$past(sBank)]
    && rowOpenPulse)
    else $error("Activate did not open bank");
  close_all_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmdOk && cmdBus.cmd == CMD_CLOSE_ALL |=> bankActive == 4'h0)
    else $error("Precharge all left a bank open");
  mode_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !allIdle |=> modeWord == $past(modeWord))
    else $error("Mode changed while a bank was active");
  gate_prev_a: assert property (@(posedge clk) disable iff (sys_rst)
    !gatePrevQ && pwrQ == PWR_RUN
    |=> bankActive == $past(bankActive))
    else $error("Command taken with gate low before");
  refresh_kind_a: assert property (@(posedge clk) disable iff (sys_rst)
    refreshPulse |-> $past(gateNow) && powerState == PWR_RUN)
    else $error("Auto refresh with gate low");
  stop_burst_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmdOk && cmdBus.cmd == CMD_BURST_STOP |=> !burstBusy)
    else $error("Burst stop ignored");
  suspend_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    pwrQ == PWR_SUSPEND && !gatePrevQ && gateNow
    |=> powerState == PWR_RUN)
    else $error("Suspend not left on gate rise");
  no_pd_burst_a: assert property (@(posedge clk) disable iff (sys_rst)
    burstBusy && pwrQ == PWR_RUN && gatePrevQ && !gateNow
    |=> powerState == PWR_SUSPEND)
    else $error("Power-down entered in a burst");

endmodule

// File: shared/sdram_cmd_pkg.sv
/*
  Constants and types shared by the command decoder and its helpers.
  Assumes a single 10 MHz clock domain and a synchronous reset.
*/
package sdram_cmd_pkg;

  // ----------------------------------------------------------------
  // Widths and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int SCOPE_BIT = 10;
  localparam int BURST_CNT_W = 9;

  // ----------------------------------------------------------------
  // Mode word fields and reset values
  // ----------------------------------------------------------------
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [BURST_CNT_W-1:0] BURST_CNT_RST = 9'h000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_OPEN_ROW,
    CMD_CLOSE_BANK,
    CMD_CLOSE_ALL,
    CMD_WRITE,
    CMD_READ,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_SLEEP_ENTRY,
    CMD_BURST_STOP
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SUSPEND,
    PWR_POWER_DOWN,
    PWR_SLEEP
  } pwr_e;

endpackage

// File: shared/cmd_if.sv
/*
  Carrier between the decoder top and its decode and data helpers.
  Assumes all signals live on the decoder's single clock.
*/
`timescale 1ns/1ps
interface cmd_if;
  import sdram_cmd_pkg::*;

  cmd_e cmd;
  logic autoPre;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic nop;
  logic bankOpen;
  logic inBurst;
  logic isWrite;
  logic [1:0] byteMask;

  modport decoder (output cmd, output autoPre, output bank, output addr,
    output nop, input bankOpen);
  modport top (input cmd, input autoPre, input bank, input addr,
    input nop, output bankOpen, output inBurst, output isWrite,
    output byteMask);
  modport data (input inBurst, input isWrite, input byteMask);
endinterface

// File: rtl/cmd_decode.sv
/*
  Combinational truth-table decoder for one sampled command edge.
  Assumes inputs are already registered on clk.
*/
`timescale 1ns/1ps
module cmd_decode
  import sdram_cmd_pkg::*;
(
  // Sampled pins
  input wire logic selectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeSelectN,
  input wire logic clockGateNow,
  input wire logic [BANK_W-1:0] bankSelect,
  input wire logic [ADDR_W-1:0] addressLines,
  // To top
  cmd_if.decoder cmdBus
);

  always_comb begin
    cmdBus.cmd = CMD_NONE;
    cmdBus.autoPre = addressLines[SCOPE_BIT];
    cmdBus.bank = bankSelect;
    cmdBus.addr = addressLines;
    cmdBus.nop = selectN || (rowStrobeN && colStrobeN && writeSelectN);
    if (!selectN) begin
      case ({rowStrobeN, colStrobeN, writeSelectN})
        3'b011: cmdBus.cmd = CMD_OPEN_ROW;
        3'b010: cmdBus.cmd = addressLines[SCOPE_BIT] ? CMD_CLOSE_ALL
          : CMD_CLOSE_BANK;
        3'b100: cmdBus.cmd = CMD_WRITE;
        3'b101: cmdBus.cmd = CMD_READ;
        3'b000: cmdBus.cmd = CMD_MODE_SET;
        3'b001: cmdBus.cmd = clockGateNow ? CMD_REFRESH
          : CMD_SLEEP_ENTRY;
        3'b110: cmdBus.cmd = CMD_BURST_STOP;
        default: cmdBus.cmd = CMD_NONE;
      endcase
    end
  end

endmodule

// File: rtl/data_gate.sv
/*
  Byte-lane gating of the data lines.
  Assumes write data and mask are registered on clk by the top.
*/
`timescale 1ns/1ps
module data_gate
  import sdram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  cmd_if.data ctl,
  // Data
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] readData,
  output logic [DATA_W-1:0] dataOut,
  output logic [DATA_W-1:0] dataOe,
  output logic [DATA_W-1:0] writeData,
  output logic [1:0] writeLaneEn
);

  logic [DATA_W-1:0] outQ, outD, oeQ, oeD, wrQ, wrD;
  logic [1:0] wenQ, wenD;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLane
      always_comb begin
        // Mask low lets the lane through, high drops it
        oeD[g*BYTE_W +: BYTE_W] = {BYTE_W{ctl.inBurst && !ctl.isWrite
          && !ctl.byteMask[g]}};
        outD[g*BYTE_W +: BYTE_W] = readData[g*BYTE_W +: BYTE_W];
        wenD[g] = ctl.inBurst && ctl.isWrite && !ctl.byteMask[g];
        wrD[g*BYTE_W +: BYTE_W] = dataIn[g*BYTE_W +: BYTE_W];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outQ <= '0;
      oeQ <= '0;
      wrQ <= '0;
      wenQ <= 2'h0;
    end else begin
      outQ <= outD;
      oeQ <= oeD;
      wrQ <= wrD;
      wenQ <= wenD;
    end
  end

  assign dataOut = outQ;
  assign dataOe = oeQ;
  assign writeData = wrQ;
  assign writeLaneEn = wenQ;

  dataoe_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctl.byteMask[0] |=> !dataOe[0])
    else $error("Low lane driven while masked");
  write_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctl.byteMask[1] |=> !writeLaneEn[1])
    else $error("High lane written while masked");

endmodule

// File: tb/sdram_ctrl_model.sv
/*
  Behavioural memory controller that drives the decoder's command,
  mask and data pins.
  Assumes the bench calls its tasks from one process, clocked on clk.
*/
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_cmd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command pins
  output logic selectN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeSelectN,
  output logic clock_gate_now,
  output logic [BANK_W-1:0] bank_select,
  output logic [ADDR_W-1:0] address_lines,
  // Masks and data
  output logic low_byte_mask,
  output logic high_byte_mask,
  output logic [DATA_W-1:0] data_lines_in
);
  logic drivePins;
  logic [DATA_W-1:0] wrValue;

  initial begin
    {selectN, rowStrobeN, colStrobeN, writeSelectN} = 4'hF;
    clock_gate_now = 1'b1;
    bank_select = 2'h0;
    address_lines = 12'h000;
    {high_byte_mask, low_byte_mask} = 2'h0;
    data_lines_in = 16'h0000;
    drivePins = 1'b0;
    wrValue = 16'h0000;
  end

  // One command a cycle, launched after an edge, held to the next edge
  task automatic issue(input logic [3:0] pins, input logic gate,
    input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr);
    @(posedge clk);
    #1;
    {selectN, rowStrobeN, colStrobeN, writeSelectN} = pins;
    clock_gate_now = gate;
    bank_select = bank;
    address_lines = addr;
    // A released bus never shows a stale value
    data_lines_in = drivePins ? wrValue : ~data_lines_in;
  endtask

  task automatic lanes(input logic [1:0] mask, input logic drive,
    input logic [DATA_W-1:0] value);
    {high_byte_mask, low_byte_mask} = mask;
    drivePins = drive;
    wrValue = value;
  endtask
endmodule

// File: tb/tb_sdram_command_decoder.sv
/*
  Self-checking bench for the command decoder, driven through the
  controller model.
  Assumes status answers three edges after the edge that launches pins.
*/
`timescale 1ns/1ps
module tb_sdram_command_decoder
  import sdram_cmd_pkg::*;
;
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_WR = 4'h4;
  localparam logic [3:0] P_RD = 4'h5;
  localparam logic [3:0] P_MRS = 4'h0;
  localparam logic [3:0] P_REF = 4'h1;
  localparam logic [3:0] P_BST = 4'h6;

  logic clk, sys_rst, selectN, rowStrobeN, colStrobeN, writeSelectN;
  logic clock_gate_now, low_byte_mask, high_byte_mask;
  logic [BANK_W-1:0] bank_select, accessBank;
  logic [ADDR_W-1:0] address_lines, rowAddr, modeWord;
  logic [DATA_W-1:0] data_lines_in, data_lines_out, data_lines_oe;
  logic [DATA_W-1:0] writeData;
  logic [DATA_W-1:0] coreRead = 16'hC3A5;
  logic [1:0] writeLaneEn;
  logic [COL_W-1:0] column;
  logic rowOpenPulse, refreshPulse, burstBusy, autoPrePending;
  logic [NUM_BANKS-1:0] bankActive;
  pwr_e powerState;
  int nFail = 0;
  int comparisons = 0;

  sdram_command_decoder u_sdram_command_decoder (.clk(clk),
    .sys_rst(sys_rst), .selectN(selectN), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .writeSelectN(writeSelectN),
    .clock_gate_now(clock_gate_now), .bank_select(bank_select),
    .address_lines(address_lines), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .readData(coreRead), .writeData(writeData),
    .writeLaneEn(writeLaneEn), .column(column), .accessBank(accessBank),
    .rowAddr(rowAddr), .rowOpenPulse(rowOpenPulse),
    .refreshPulse(refreshPulse), .bankActive(bankActive),
    .modeWord(modeWord), .burstBusy(burstBusy),
    .autoPrePending(autoPrePending), .powerState(powerState));

  sdram_ctrl_model u_sdram_ctrl_model (.clk(clk), .selectN(selectN),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeSelectN(writeSelectN), .clock_gate_now(clock_gate_now),
    .bank_select(bank_select), .address_lines(address_lines),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
    .data_lines_in(data_lines_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic op(input logic [3:0] p, input logic g,
    input logic [1:0] b, input logic [11:0] a);
    u_sdram_ctrl_model.issue(p, g, b, a);
  endtask

  // Enough edges for a command's effect to show
  task automatic idle(input int n, input logic g);
    repeat (n) u_sdram_ctrl_model.issue(P_NOP, g, 2'h0, 12'h000);
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tActivate();
    for (int b = 0; b < 4; b++) begin
      op(P_ACT, 1'b1, 2'(b), 12'hA00 + 12'(b));
      idle(3, 1'b1);
      chk("rowOpenPulse", 16'h0001, {15'h0, rowOpenPulse});
      chk("rowAddr", 16'h0A00 + 16'(b), {4'h0, rowAddr});
      chk("bankActive", 16'((2 << b) - 1), {12'h0, bankActive});
    end
    idle(1, 1'b1);
    chk("rowOpenPulse", 16'h0000, {15'h0, rowOpenPulse});
    $display("done activate");
  endtask

  task automatic tPrecharge();
    op(P_PRE, 1'b1, 2'h2, 12'h000);
    idle(4, 1'b1);
    chk("bankActive", 16'h000B, {12'h0, bankActive});
    op(P_PRE, 1'b1, 2'h1, 12'h400);
    idle(4, 1'b1);
    chk("bankActive", 16'h0000, {12'h0, bankActive});
    op(4'hB, 1'b1, 2'h1, 12'h123);
    idle(4, 1'b1);
    chk("bankActive", 16'h0000, {12'h0, bankActive});
    $display("done precharge");
  endtask

  task automatic tModeRefresh();
    op(P_ACT, 1'b1, 2'h0, 12'h001);
    idle(4, 1'b1);
    op(P_MRS, 1'b1, 2'h0, 12'h037);
    idle(4, 1'b1);
    chk("modeWord", 16'h0000, {4'h0, modeWord});
    op(P_PRE, 1'b1, 2'h3, 12'h400);
    idle(4, 1'b1);
    op(P_MRS, 1'b1, 2'h0, 12'h007);
    idle(4, 1'b1);
    chk("modeWord", 16'h0007, {4'h0, modeWord});
    op(P_REF, 1'b1, 2'h0, 12'h000);
    idle(3, 1'b1);
    chk("refreshPulse", 16'h0001, {15'h0, refreshPulse});
    $display("done mode and refresh");
  endtask

  task automatic tBurst();
    op(P_ACT, 1'b1, 2'h1, 12'h055);
    idle(4, 1'b1);
    u_sdram_ctrl_model.lanes(2'b10, 1'b1, 16'hA55A);
    op(P_WR, 1'b1, 2'h1, 12'h1A5);
    idle(3, 1'b1);
    chk("column", 16'h01A5, {7'h0, column});
    chk("accessBank", 16'h0001, {14'h0, accessBank});
    chk("burstBusy", 16'h0001, {15'h0, burstBusy});
    chk("autoPrePending", 16'h0000, {15'h0, autoPrePending});
    idle(2, 1'b1);
    chk("writeLaneEn", 16'h0001, {14'h0, writeLaneEn});
    chk("writeData", 16'h005A, {8'h0, writeData[7:0]});
    op(P_BST, 1'b1, 2'h3, 12'hFFF);
    idle(4, 1'b1);
    chk("burstBusy", 16'h0000, {15'h0, burstBusy});
    u_sdram_ctrl_model.lanes(2'b01, 1'b0, 16'h0000);
    op(P_RD, 1'b1, 2'h1, 12'h0F0);
    idle(6, 1'b1);
    chk("burstBusy", 16'h0001, {15'h0, burstBusy});
    chk("data_lines_oe", 16'hFF00, data_lines_oe);
    chk("data_lines_out", 16'h00C3, {8'h0, data_lines_out[15:8]});
    op(P_BST, 1'b1, 2'h0, 12'h000);
    idle(4, 1'b1);
    chk("burstBusy", 16'h0000, {15'h0, burstBusy});
    $display("done burst");
  endtask

  task automatic pwr(input logic [3:0] p, input logic g, input pwr_e e,
    input string what);
    op(p, g, 2'h0, 12'h000);
    idle(4, g);
    chk(what, {14'h0, e}, {14'h0, powerState});
  endtask

  task automatic tPower();
    pwr(P_BST, 1'b0, PWR_SUSPEND, "suspend entry");
    pwr(P_NOP, 1'b1, PWR_RUN, "suspend exit");
    op(P_RD, 1'b1, 2'h1, 12'h010);
    idle(4, 1'b1);
    pwr(P_NOP, 1'b0, PWR_SUSPEND, "entry in burst");
    pwr(P_NOP, 1'b1, PWR_RUN, "exit in burst");
    op(P_BST, 1'b1, 2'h0, 12'h000);
    op(P_PRE, 1'b1, 2'h0, 12'h400);
    idle(4, 1'b1);
    pwr(P_NOP, 1'b0, PWR_POWER_DOWN, "power-down entry");
    pwr(P_NOP, 1'b1, PWR_RUN, "power-down exit");
    pwr(P_REF, 1'b0, PWR_SLEEP, "sleep entry");
    pwr(P_NOP, 1'b1, PWR_RUN, "sleep exit");
    $display("done power");
  endtask

  task automatic tGateAutoPre();
    op(P_ACT, 1'b0, 2'h3, 12'h000);
    op(P_ACT, 1'b1, 2'h1, 12'h000);
    idle(3, 1'b1);
    chk("bankActive", 16'h0008, {12'h0, bankActive});
    op(P_PRE, 1'b1, 2'h0, 12'h400);
    op(P_MRS, 1'b1, 2'h0, 12'h002);
    op(P_ACT, 1'b1, 2'h2, 12'h0C0);
    idle(2, 1'b1);
    op(P_WR, 1'b1, 2'h2, 12'h404);
    idle(3, 1'b1);
    chk("modeWord", 16'h0002, {4'h0, modeWord});
    chk("autoPrePending", 16'h0001, {15'h0, autoPrePending});
    chk("column", 16'h0004, {7'h0, column});
    idle(4, 1'b1);
    chk("bankActive", 16'h0000, {12'h0, bankActive});
    chk("burstBusy", 16'h0000, {15'h0, burstBusy});
    $display("done gate and auto-precharge");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    idle(3, 1'b1);
    chk("bankActive", 16'h0000, {12'h0, bankActive});
    chk("powerState", {14'h0, PWR_RUN}, {14'h0, powerState});
    tActivate();
    tPrecharge();
    tModeRefresh();
    tBurst();
    tPower();
    tGateAutoPre();
    printVerdict();
  end

  initial begin
    #500000;
    nFail++;
    $display("watchdog expired");
    printVerdict();
  end
endmodule
